// [src/cst_regs.svh]
// Register offsets, field positions, reset and preset values of the state trigger.
// Assumes a 32-bit register port with byte offsets in an 8-bit address.
`ifndef CST_REGS_SVH
`define CST_REGS_SVH
// ****************************************************************
// Offsets
// ****************************************************************
`define CST_A_CFG 8'h00
`define CST_A_PAT_CH 8'h04
`define CST_A_PAT_AUX 8'h08
`define CST_A_SEL 8'h0c
`define CST_A_THR_MAIN 8'h10
`define CST_A_THR_DLY 8'h14
`define CST_A_CMD 8'h18
`define CST_A_VDIV 8'h1c
`define CST_A_STATUS 8'h20
// ****************************************************************
// Fields
// ****************************************************************
`define CST_CFG_SRC 4:0
`define CST_CFG_FALL 8
`define CST_CFG_FN 13:12
`define CST_CFG_ARM 16
`define CST_PAT_AUX 1:0
`define CST_SEL 4:0
`define CST_THR 15:0
`define CST_VDIV 15:0
`define CST_CMD_GROUP 0
`define CST_CMD_ALL 1
`define CST_CMD_TT 2
`define CST_CMD_POS_EC 3
`define CST_CMD_NEG_EC 4
`define CST_CMD_COMP 5
`define CST_ST_BUSY 0
`define CST_ST_WAIT 1
`define CST_ST_FIRED 2
// ****************************************************************
// Values
// ****************************************************************
`define CST_PAT_LOW 2'h1
`define CST_PAT_HIGH 2'h2
`define CST_SRC_MAX 5'h10
`define CST_SEL_MIN 5'h01
`define CST_SEL_AUX 5'h11
`define CST_VDIV_RST 16'h03e8
`define CST_THR_AUX 16'h05dc
`define CST_THR_TT 16'h0578
`define CST_THR_POS_EC 16'h0e74
`define CST_THR_NEG_EC 16'hfaec
`define CST_THR_COMP 16'h09c4
`define CST_DIV_RANGE 22'h00000c
`endif

// [src/cst_pkg.sv]
// Types of the clocked state trigger.
// Assumes nothing beyond the register header.
package cst_pkg;
  typedef enum logic [1:0] {CST_FN_AND = 2'h0, CST_FN_NAND = 2'h1, CST_FN_OR = 2'h2,
    CST_FN_NOR = 2'h3} cst_fn_e;
  typedef enum logic [1:0] {CST_HOLD = 2'h0, CST_WAIT = 2'h1, CST_FIRE = 2'h3} cst_state_e;
  typedef logic [15:0] cst_thr_t;
endpackage

// [src/cst_thr_if.sv]
// Port bundle between the trigger controller and its threshold table.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface cst_thr_if #(parameter int AW = 4, parameter int DW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [src/cst_sync.sv]
// Three-stage input synchroniser with two-stage agreement.
// Assumes asynchronous inputs and a synchronous active-low reset.
`timescale 1ns/1ps
module cst_sync #(parameter int W = 17)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] stable_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_stable;

  // ****************************************************************
  // Accept a level once the second and third stage agree
  // ****************************************************************
  always_comb
  begin
    next_stable = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & stable_out);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stable_out <= '0;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      stable_out <= next_stable;
    end
  end
endmodule

// [src/cst_thr_mem.sv]
// Shared threshold table, one word per channel, registered write-first read.
// Assumes the controller never needs the table cleared at reset.
`timescale 1ns/1ps
module cst_thr_mem #(parameter int DEPTH = 16, parameter int AW = 4, parameter int DW = 16)
(
  input wire logic sys_clk,
  cst_thr_if.mem port
);
  logic [DW-1:0] store [DEPTH];
  logic [DW-1:0] next_rdata;

  // ****************************************************************
  // Read with bypass of a write to the same word
  // ****************************************************************
  always_comb
  begin
    next_rdata = (port.we && port.waddr == port.raddr) ? port.wdata : store[port.raddr];
  end

  always_ff @(posedge sys_clk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= next_rdata;
  end
endmodule

// [src/cst_trigger.sv]
// Clocked state trigger with its shared threshold table and register port.
// Assumes probe pins are asynchronous and holdoff_active comes from logic on sys_clk.
//
// Behaviour
// - After holdoff, wait for chosen clock edge
// - Compare inputs to pattern, skip don't-care
// - Compare sixteen channels plus auxiliary input
// - True comparison fires trigger at once
// - AND: every compared input matches
// - NAND: at least one compared input differs
// - OR: at least one compared input matches
// - NOR: every compared input differs
// - Selector one to sixteen channels, seventeen auxiliary
// - Auxiliary threshold fixed 1.5 V, writes ignored
// - One threshold shared by main and delayed
// - Group copy writes selected threshold to group
// - Global copy writes selected threshold everywhere
// - Presets load 1.4, 3.7 and 2.5 V
// - Negative emitter-coupled preset loads minus 1.3 V
// - Thresholds clamped to twelve divisions
// - All don't-care never triggers
// - Clock source input excluded from pattern
// - Clock source any input, rising or falling
`timescale 1ns/1ps
`include "cst_regs.svh"
module cst_trigger
  import cst_pkg::*;
#(
  parameter int N_CH = 16,
  parameter int GROUP_SIZE = 4,
  parameter logic [15:0] VDIV_RST = `CST_VDIV_RST
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic [N_CH-1:0] probe_in,
  input wire logic aux_in,
  input wire logic holdoff_active,
  output logic trig_event,
  output logic trig_armed
);
  localparam int NI = N_CH + 1;
  localparam int AW = $clog2(N_CH);

  logic [NI-1:0] in_now;
  logic [4:0] clk_src;
  logic clk_fall;
  cst_fn_e fn;
  logic arm;
  logic [2*NI-1:0] pat;
  logic [4:0] sel;
  logic [15:0] vdiv;
  logic fired;
  logic busy;
  logic [AW-1:0] walk_idx;
  logic [AW-1:0] walk_last;
  cst_thr_t walk_val;
  cst_state_e state;
  logic clk_prev;
  logic [4:0] next_clk_src;
  logic next_clk_fall;
  cst_fn_e next_fn;
  logic next_arm;
  logic [2*NI-1:0] next_pat;
  logic [4:0] next_sel;
  logic [15:0] next_vdiv;
  logic next_fired;
  logic next_busy;
  logic [AW-1:0] next_walk_idx;
  logic [AW-1:0] next_walk_last;
  cst_thr_t next_walk_val;
  logic [31:0] next_rdata;
  cst_state_e next_state;
  logic next_trig;
  logic clk_cur;
  logic edge_seen;
  logic [NI-1:0] care;
  logic [NI-1:0] match;
  logic any_care;
  logic all_match;
  logic any_match;
  logic hit;
  logic sel_aux;
  logic [AW-1:0] sel_idx;
  cst_thr_t sel_thr;
  logic wr_thr;
  logic wr_cmd;

  cst_thr_if #(.AW(AW), .DW(16)) thr ();

  cst_sync #(.W(NI)) u_sync
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({aux_in, probe_in}),
    .stable_out(in_now)
  );

  cst_thr_mem #(.DEPTH(N_CH), .AW(AW), .DW(16)) u_thr
  (
    .sys_clk(sys_clk),
    .port(thr.mem)
  );

  function automatic cst_thr_t clamp_thr(input cst_thr_t v, input logic [15:0] div);
    logic signed [21:0] lim;
    logic signed [21:0] sv;
    lim = signed'(22'({6'h00, div}) * `CST_DIV_RANGE);
    sv = signed'({{6{v[15]}}, v});
    if (sv > lim)
      clamp_thr = lim[15:0];
    else if (sv < -lim)
      clamp_thr = 16'(-lim);
    else
      clamp_thr = v;
  endfunction

  // ****************************************************************
  // Pattern comparison
  // ****************************************************************
  always_comb
  begin
    clk_cur = in_now[clk_src];
    edge_seen = clk_fall ? (clk_prev & ~clk_cur) : (~clk_prev & clk_cur);
    for (int i = 0; i < NI; i++)
    begin
      care[i] = (pat[2*i +: 2] == `CST_PAT_LOW || pat[2*i +: 2] == `CST_PAT_HIGH)
        && (5'(i) != clk_src);
      match[i] = in_now[i] == (pat[2*i +: 2] == `CST_PAT_HIGH);
    end
    any_care = |care;
    all_match = &(match | ~care);
    any_match = |(match & care);
    unique case (fn)
      CST_FN_AND: hit = all_match;
      CST_FN_NAND: hit = ~all_match;
      CST_FN_OR: hit = any_match;
      CST_FN_NOR: hit = ~any_match;
    endcase
  end

  // ****************************************************************
  // Trigger sequencer
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_trig = 1'b0;
    unique case (state)
      CST_HOLD:
      begin
        if (arm && !holdoff_active)
          next_state = CST_WAIT;
      end
      CST_WAIT:
      begin
        if (!arm || holdoff_active)
          next_state = CST_HOLD;
        else if (edge_seen && any_care && hit)
        begin
          next_state = CST_FIRE;
          next_trig = 1'b1;
        end
      end
      CST_FIRE:
      begin
        next_state = CST_HOLD;
      end
    endcase
  end

  // ****************************************************************
  // Registers and threshold table access
  // ****************************************************************
  always_comb
  begin
    sel_aux = sel == `CST_SEL_AUX;
    sel_idx = AW'(sel - `CST_SEL_MIN);
    sel_thr = sel_aux ? `CST_THR_AUX : thr.rdata;
    wr_thr = bus_wr && (bus_addr == `CST_A_THR_MAIN || bus_addr == `CST_A_THR_DLY);
    wr_cmd = bus_wr && bus_addr == `CST_A_CMD && !busy;
    next_clk_src = clk_src;
    next_clk_fall = clk_fall;
    next_fn = fn;
    next_arm = arm;
    next_pat = pat;
    next_sel = sel;
    next_vdiv = vdiv;
    next_fired = fired | next_trig;
    next_busy = busy;
    next_walk_idx = walk_idx;
    next_walk_last = walk_last;
    next_walk_val = walk_val;
    thr.we = 1'b0;
    thr.waddr = sel_idx;
    thr.wdata = clamp_thr(bus_wdata[`CST_THR], vdiv);
    if (bus_wr)
    begin
      unique case (bus_addr)
        `CST_A_CFG:
        begin
          if (bus_wdata[`CST_CFG_SRC] <= `CST_SRC_MAX)
            next_clk_src = bus_wdata[`CST_CFG_SRC];
          next_clk_fall = bus_wdata[`CST_CFG_FALL];
          next_fn = cst_fn_e'(bus_wdata[`CST_CFG_FN]);
          next_arm = bus_wdata[`CST_CFG_ARM];
        end
        `CST_A_PAT_CH: next_pat[2*N_CH-1:0] = bus_wdata[2*N_CH-1:0];
        `CST_A_PAT_AUX: next_pat[2*NI-1 -: 2] = bus_wdata[`CST_PAT_AUX];
        `CST_A_SEL:
        begin
          if (bus_wdata[`CST_SEL] >= `CST_SEL_MIN && bus_wdata[`CST_SEL] <= `CST_SEL_AUX)
            next_sel = bus_wdata[`CST_SEL];
        end
        `CST_A_VDIV: next_vdiv = bus_wdata[`CST_VDIV];
        `CST_A_STATUS: next_fired = next_trig | (fired & ~bus_wdata[`CST_ST_FIRED]);
        default:
        begin
        end
      endcase
    end
    if (busy)
    begin
      thr.we = 1'b1;
      thr.waddr = walk_idx;
      thr.wdata = walk_val;
      next_walk_idx = AW'(walk_idx + 1'b1);
      next_busy = walk_idx != walk_last;
    end
    else if (wr_thr && !sel_aux)
    begin
      thr.we = 1'b1;
    end
    else if (wr_cmd && !sel_aux && bus_wdata[`CST_CMD_GROUP])
    begin
      next_busy = 1'b1;
      next_walk_val = sel_thr;
      next_walk_idx = AW'((int'(sel_idx) / GROUP_SIZE) * GROUP_SIZE);
      next_walk_last = AW'((int'(sel_idx) / GROUP_SIZE) * GROUP_SIZE + GROUP_SIZE - 1);
    end
    else if (wr_cmd && bus_wdata[`CST_CMD_ALL])
    begin
      next_busy = 1'b1;
      next_walk_val = sel_thr;
      next_walk_idx = '0;
      next_walk_last = AW'(N_CH - 1);
    end
    else if (wr_cmd && !sel_aux && |bus_wdata[`CST_CMD_COMP:`CST_CMD_TT])
    begin
      thr.we = 1'b1;
      if (bus_wdata[`CST_CMD_TT])
        thr.wdata = clamp_thr(`CST_THR_TT, vdiv);
      else if (bus_wdata[`CST_CMD_POS_EC])
        thr.wdata = clamp_thr(`CST_THR_POS_EC, vdiv);
      else if (bus_wdata[`CST_CMD_NEG_EC])
        thr.wdata = clamp_thr(`CST_THR_NEG_EC, vdiv);
      else
        thr.wdata = clamp_thr(`CST_THR_COMP, vdiv);
    end
    thr.raddr = AW'(next_sel - `CST_SEL_MIN);
    next_rdata = '0;
    if (bus_rd)
    begin
      unique case (bus_addr)
        `CST_A_CFG:
        begin
          next_rdata[`CST_CFG_SRC] = clk_src;
          next_rdata[`CST_CFG_FALL] = clk_fall;
          next_rdata[`CST_CFG_FN] = fn;
          next_rdata[`CST_CFG_ARM] = arm;
        end
        `CST_A_PAT_CH: next_rdata[2*N_CH-1:0] = pat[2*N_CH-1:0];
        `CST_A_PAT_AUX: next_rdata[`CST_PAT_AUX] = pat[2*NI-1 -: 2];
        `CST_A_SEL: next_rdata[`CST_SEL] = sel;
        `CST_A_THR_MAIN, `CST_A_THR_DLY: next_rdata[`CST_THR] = sel_thr;
        `CST_A_VDIV: next_rdata[`CST_VDIV] = vdiv;
        `CST_A_STATUS:
        begin
          next_rdata[`CST_ST_BUSY] = busy;
          next_rdata[`CST_ST_WAIT] = state == CST_WAIT;
          next_rdata[`CST_ST_FIRED] = fired;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      clk_src <= '0;
      clk_fall <= 1'b0;
      fn <= CST_FN_AND;
      arm <= 1'b0;
      pat <= '0;
      sel <= `CST_SEL_MIN;
      vdiv <= VDIV_RST;
      fired <= 1'b0;
      busy <= 1'b0;
      walk_idx <= '0;
      walk_last <= '0;
      walk_val <= '0;
      state <= CST_HOLD;
      clk_prev <= 1'b0;
      trig_event <= 1'b0;
      trig_armed <= 1'b0;
      bus_rdata <= '0;
    end
    else
    begin
      clk_src <= next_clk_src;
      clk_fall <= next_clk_fall;
      fn <= next_fn;
      arm <= next_arm;
      pat <= next_pat;
      sel <= next_sel;
      vdiv <= next_vdiv;
      fired <= next_fired;
      busy <= next_busy;
      walk_idx <= next_walk_idx;
      walk_last <= next_walk_last;
      walk_val <= next_walk_val;
      state <= next_state;
      clk_prev <= clk_cur;
      trig_event <= next_trig;
      trig_armed <= next_state == CST_WAIT;
      bus_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_HOLDOFF: assert property (holdoff_active |=> !trig_event)
    else $error("Trigger during holdoff");
  AST_EDGE: assert property (trig_event |-> $past(edge_seen) && $past(state) == CST_WAIT)
    else $error("Trigger without clock edge");
  AST_ALL_DC: assert property (!any_care |=> !trig_event)
    else $error("Trigger with empty pattern");
  AST_AND: assert property (state == CST_WAIT && arm && !holdoff_active && edge_seen
    && fn == CST_FN_AND && any_care && (match & care) == care |=> trig_event)
    else $error("AND match missed");
  AST_NAND: assert property (trig_event && $past(fn) == CST_FN_NAND
    |-> $past((match & care) != care))
    else $error("NAND fired on full match");
  AST_OR: assert property (trig_event && $past(fn) == CST_FN_OR
    |-> $past((match & care) != '0))
    else $error("OR fired without match");
  AST_NOR: assert property (trig_event && $past(fn) == CST_FN_NOR
    |-> $past((match & care) == '0))
    else $error("NOR fired with a match");
  AST_CLKSRC: assert property (care[clk_src] == 1'b0)
    else $error("Clock source compared");
  AST_AUX_THR: assert property (bus_rd && bus_addr == `CST_A_THR_MAIN && sel == `CST_SEL_AUX
    |=> bus_rdata[`CST_THR] == `CST_THR_AUX)
    else $error("Auxiliary threshold not fixed");
  AST_GLOBAL: assert property (!busy && wr_cmd && bus_wdata[`CST_CMD_ALL]
    && !bus_wdata[`CST_CMD_GROUP] |=> busy [*8] ##1 busy [*8] ##1 !busy)
    else $error("Global copy length wrong");
  AST_CLAMP: assert property (thr.we |-> signed'({{6{thr.wdata[15]}}, thr.wdata})
    <= signed'(22'({6'h00, vdiv}) * `CST_DIV_RANGE))
    else $error("Threshold above range");
  AST_ONE: assert property (trig_event |=> !trig_event)
    else $error("Trigger longer than one cycle");

  COV_AND: cover property (trig_event && $past(fn) == CST_FN_AND);
  COV_NOR: cover property (trig_event && $past(fn) == CST_FN_NOR);
  COV_GROUP: cover property ($fell(busy));
  COV_PRESET: cover property (wr_cmd && bus_wdata[`CST_CMD_NEG_EC]);
endmodule

// [tb/cst_sig_model.sv]
// Model of the logic signals under test on the probed inputs.
// Assumes the bench sets the wanted levels just after a sys_clk edge.
`timescale 1ns/1ps
module cst_sig_model
(
  input wire logic [15:0] want_ch,
  input wire logic want_aux,
  output logic [15:0] probe_in,
  output logic aux_in
);
  // ****************************************************************
  // Pins
  // ****************************************************************
  // Levels land mid-cycle, 2 ns after the sys_clk edge at which the bench sets them
  initial
  begin
    probe_in = 16'h0000;
    aux_in = 1'b0;
  end
  always @(want_ch) probe_in <= #2 want_ch;
  always @(want_aux) aux_in <= #2 want_aux;
endmodule

// [tb/testbench.sv]
// Self-checking bench of the clocked state trigger.
// Assumes the register map and timing of the trigger's register port.
`timescale 1ns/1ps
`include "cst_regs.svh"
module testbench;
  import cst_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h00000000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic [15:0] want_ch = 16'h0000;
  logic want_aux = 1'b0;
  logic [15:0] probe_in;
  logic aux_in;
  logic holdoff_active = 1'b0;
  logic trig_event;
  logic trig_armed;
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] d;
  logic [33:0] p;
  logic [16:0] v;
  logic [16:0] c;
  logic [16:0] fl;
  cst_trigger u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .probe_in(probe_in), .aux_in(aux_in), .holdoff_active(holdoff_active),
    .trig_event(trig_event), .trig_armed(trig_armed));
  cst_sig_model u_sig (.want_ch(want_ch), .want_aux(want_aux), .probe_in(probe_in),
    .aux_in(aux_in));
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= dat;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    dat = bus_rdata;
  endtask
  task thr_chk(input logic [4:0] sel, input logic [15:0] exp);
    wr(`CST_A_SEL, {27'h0, sel});
    rd(`CST_A_THR_MAIN, d);
    check("threshold", {16'h0, d[15:0]}, {16'h0, exp});
  endtask
  task wait_idle;
    int k;
    k = 0;
    rd(`CST_A_STATUS, d);
    while (d[`CST_ST_BUSY] === 1'b1 && k < 40)
    begin
      rd(`CST_A_STATUS, d);
      k++;
    end
    check("busy", {31'h0, d[`CST_ST_BUSY]}, 32'h0);
  endtask
  // Expected verdict of one clocked comparison
  function automatic logic exp_fire(logic [1:0] fn, logic [33:0] pat, logic [16:0] ins,
    int src);
    int nc;
    int nm;
    nc = 0;
    nm = 0;
    for (int i = 0; i < 17; i++)
      if (i != src && (pat[2*i+:2] == 2'h1 || pat[2*i+:2] == 2'h2))
      begin
        nc++;
        if (ins[i] == (pat[2*i+:2] == 2'h2))
          nm++;
      end
    if (nc == 0)
      return 1'b0;
    case (fn)
      2'h0: return nm == nc;
      2'h1: return nm < nc;
      2'h2: return nm > 0;
      default: return nm == 0;
    endcase
  endfunction
  task trial(input logic [1:0] fn, input logic [33:0] pat, input logic [16:0] ins,
    input logic [4:0] src, input logic fall, input logic hold);
    logic [16:0] w;
    logic fired;
    logic e;
    w = ins;
    e = exp_fire(fn, pat, ins, src) && !hold;
    w[src] = fall;
    @(posedge sys_clk);
    holdoff_active <= hold;
    want_ch <= w[15:0];
    want_aux <= w[16];
    wr(`CST_A_PAT_CH, pat[31:0]);
    wr(`CST_A_PAT_AUX, {30'h0, pat[33:32]});
    wr(`CST_A_CFG, {15'h0, 1'b1, 2'h0, fn, 3'h0, fall, 3'h0, src});
    repeat (8) @(posedge sys_clk);
    #1;
    check("armed", {31'h0, trig_armed}, {31'h0, !hold});
    w[src] = ~fall;
    @(posedge sys_clk);
    want_ch <= w[15:0];
    want_aux <= w[16];
    fired = 1'b0;
    repeat (10)
    begin
      @(posedge sys_clk);
      #1;
      if (trig_event === 1'b1)
        fired = 1'b1;
    end
    check("trigger", {31'h0, fired}, {31'h0, e});
    rd(`CST_A_STATUS, d);
    check("fired flag", {31'h0, d[`CST_ST_FIRED]}, {31'h0, e});
    check("waiting", {31'h0, d[`CST_ST_WAIT]}, {31'h0, !hold});
    wr(`CST_A_STATUS, 32'h4);
    wr(`CST_A_CFG, 32'h0);
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'he8cb));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`CST_A_VDIV, d);
    check("vdiv reset", d, {16'h0, `CST_VDIV_RST});
    rd(8'h40, d);
    check("unmapped", d, 32'h0);
    wr(`CST_A_SEL, 32'h3);
    wr(`CST_A_THR_MAIN, 32'h1f4);
    rd(`CST_A_THR_DLY, d);
    check("delayed", {16'h0, d[15:0]}, 32'h1f4);
    wr(`CST_A_SEL, 32'h11);
    wr(`CST_A_THR_DLY, 32'h64);
    rd(`CST_A_THR_MAIN, d);
    check("aux", {16'h0, d[15:0]}, {16'h0, `CST_THR_AUX});
    wr(`CST_A_SEL, 32'h2);
    wr(`CST_A_CMD, 32'h4);
    thr_chk(5'h2, `CST_THR_TT);
    wr(`CST_A_CMD, 32'h8);
    thr_chk(5'h2, `CST_THR_POS_EC);
    wr(`CST_A_CMD, 32'h10);
    thr_chk(5'h2, `CST_THR_NEG_EC);
    wr(`CST_A_CMD, 32'h20);
    thr_chk(5'h2, `CST_THR_COMP);
    wr(`CST_A_VDIV, 32'h64);
    wr(`CST_A_CMD, 32'h4);
    thr_chk(5'h2, 16'h04b0);
    wr(`CST_A_THR_MAIN, 32'h0000d8f0);
    thr_chk(5'h2, 16'hfb50);
    wr(`CST_A_VDIV, 32'h3e8);
    wr(`CST_A_SEL, 32'h5);
    wr(`CST_A_THR_MAIN, 32'h2bc);
    wr(`CST_A_CMD, 32'h2);
    rd(`CST_A_STATUS, d);
    check("busy copy", {31'h0, d[`CST_ST_BUSY]}, 32'h1);
    wait_idle();
    for (int i = 1; i <= 16; i++)
      thr_chk(i[4:0], 16'h02bc);
    wr(`CST_A_SEL, 32'h6);
    wr(`CST_A_THR_MAIN, 32'h384);
    wr(`CST_A_CMD, 32'h1);
    wait_idle();
    for (int i = 4; i <= 9; i++)
      thr_chk(i[4:0], (i >= 5 && i <= 8) ? 16'h0384 : 16'h02bc);
    trial(2'h2, 34'h0, 17'h1ffff, 5'h0, 1'b0, 1'b0);
    trial(2'h1, 34'h0, 17'h00000, 5'h0, 1'b0, 1'b0);
    trial(2'h0, 34'h9, 17'h00002, 5'h0, 1'b0, 1'b0);
    trial(2'h0, 34'h200000000, 17'h10000, 5'h0, 1'b0, 1'b0);
    trial(2'h0, 34'h200000000, 17'h00000, 5'h0, 1'b0, 1'b0);
    trial(2'h0, 34'h2, 17'h00001, 5'h10, 1'b1, 1'b0);
    trial(2'h0, 34'h8, 17'h00002, 5'h0, 1'b0, 1'b1);
    for (int t = 0; t < 60; t++)
    begin
      v = $urandom;
      c = $urandom;
      fl = $urandom & $urandom & $urandom;
      for (int i = 0; i < 17; i++)
        p[2*i+:2] = !c[i] ? 2'h0 : (v[i] ^ fl[i]) ? 2'h2 : 2'h1;
      trial(t[1:0], p, v, 5'($urandom % 17), 1'($urandom), 1'b0);
    end
    finish_test();
  end
endmodule
